// ---- rtl/fpc_cfg.svh ----
// fast ethernet coding block: code-groups, lock counts and scrambler constants
// assumes one bit per clock on the line side, five clocks per code-group
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

`define FPC_CG_IDLE 5'h1f
`define FPC_CG_SSD1 5'h18
`define FPC_CG_SSD2 5'h11
`define FPC_CG_ESD1 5'h0d
`define FPC_CG_ESD2 5'h07
`define FPC_CG_HALT 5'h04
`define FPC_CG_LPI 5'h00
`define FPC_NIB_LPI 4'h1

`define FPC_CG_BITS 3'h5
`define FPC_CG_LAST 3'h4
`define FPC_ZERO_TAIL 3'h2

`define FPC_LOCK_ONES 7'h58
`define FPC_SSD_ERRS 2'h3

`define FPC_LFSR_SEED 11'h7ff
`define FPC_TAP_HI 10
`define FPC_TAP_LO 8

`define FPC_BUF_W 6
`define FPC_BUF_D 2

`endif

// ---- rtl/fpc_pkg.sv ----
// state types of the fast ethernet coding block
// assumes nothing from fpc_cfg.svh; the state encodings are written out here
`default_nettype none

package fpc_pkg;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_SSD2 = 2'h1,
        TX_DATA = 2'h2,
        TX_ESD2 = 2'h3
    } fpc_tx_state_t;

    typedef enum logic [2:0] {
        RX_WAITZ = 3'h0,
        RX_CHKJ = 3'h1,
        RX_CHKK = 3'h2,
        RX_DATA = 3'h3,
        RX_ESD2 = 3'h4,
        RX_LPI = 3'h5
    } fpc_rx_state_t;

endpackage

`default_nettype wire

// ---- rtl/fpc_buf.sv ----
// two-entry valid/ready buffer for transmit nibble words
// assumes both sides on clk_i; depth must be a power of two
`default_nettype none

module fpc_buf #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != FULL);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else if (push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            case ({push, pop})
                2'b10: cnt_q <= cnt_q + 1'b1;
                2'b01: cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end

    // a full buffer with a stalled drain must stay full and refuse input
    a_buf_full_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cnt_q == FULL && !out_ready_i) |=> (cnt_q == FULL && !in_ready_o))
        else $error("buffer lost or gained a word while stalled");

endmodule

`default_nettype wire

// ---- rtl/fpc_top.sv ----
// 100 Mbps physical coding: 4b/5b encode, scramble, nrzi on transmit;
// nrzi decode, descramble lock, alignment and 4b/5b decode on receive
// assumes the mac sits on clk_i; rx_line_i is an asynchronous pin
`default_nettype none
`include "fpc_cfg.svh"

module fpc_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    input wire logic [3:0] txd_i,
    input wire logic scr_bypass_i,
    input wire logic fiber_mode_i,
    output logic tx_line_o,
    input wire logic rx_line_i,
    output logic rx_valid_o,
    output logic rx_dv_o,
    output logic rx_er_o,
    output logic [3:0] rxd_o,
    output logic rx_locked_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    function automatic logic [4:0] fpc_enc(input logic [3:0] nib);
        logic [4:0] cg;
        cg = 5'h1e;
        case (nib)
            4'h0: cg = 5'h1e;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0a;
            4'h5: cg = 5'h0b;
            4'h6: cg = 5'h0e;
            4'h7: cg = 5'h0f;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'ha: cg = 5'h16;
            4'hb: cg = 5'h17;
            4'hc: cg = 5'h1a;
            4'hd: cg = 5'h1b;
            4'he: cg = 5'h1c;
            default: cg = 5'h1d;
        endcase
        return cg;
    endfunction

    // returns {valid, nibble}; anything outside the data table is invalid
    function automatic logic [4:0] fpc_dec(input logic [4:0] cg);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            if (fpc_enc(4'(i)) == cg)
            begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    // transmit side
    logic b_valid;
    logic b_ready;
    logic [`FPC_BUF_W-1:0] b_data;
    logic pop_en;
    logic pop_er;
    logic [3:0] pop_d;
    logic [2:0] tx_cnt_q;
    logic tx_ld;
    logic [4:0] tx_sh_q;
    logic [4:0] tx_code;
    logic [4:0] tx_enc;
    fpc_pkg::fpc_tx_state_t tx_st_q;
    fpc_pkg::fpc_tx_state_t tx_st_d;
    logic [10:0] tx_lfsr_q;
    logic tx_key;
    logic tx_byp;
    logic tx_bit;
    logic tx_line_q;

    // two entries let the mac run ahead while the serializer drains a group
    fpc_buf #(
        .WIDTH(`FPC_BUF_W),
        .DEPTH(`FPC_BUF_D)
    ) u_txbuf (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i({tx_en_i, tx_er_i, txd_i}),
        .out_valid_o(b_valid),
        .out_ready_i(b_ready),
        .out_data_o(b_data)
    );

    // an empty buffer reads as an idle word, so underrun mid-frame ends the frame
    assign pop_en = b_valid && b_data[5];
    assign pop_er = b_valid && b_data[4];
    assign pop_d = b_data[3:0];
    assign tx_ld = (tx_cnt_q == `FPC_CG_LAST);
    assign b_ready = tx_ld && (tx_st_q != fpc_pkg::TX_ESD2);
    assign tx_enc = fpc_enc(pop_d);

    always_comb
    begin
        tx_st_d = tx_st_q;
        tx_code = `FPC_CG_IDLE;
        case (tx_st_q)
            fpc_pkg::TX_IDLE:
            begin
                if (pop_en)
                begin
                    tx_code = `FPC_CG_SSD1;
                    tx_st_d = fpc_pkg::TX_SSD2;
                end
                else if (pop_er && pop_d == `FPC_NIB_LPI)
                begin
                    tx_code = `FPC_CG_LPI;
                end
                else
                begin
                    tx_code = `FPC_CG_IDLE;
                end
            end
            fpc_pkg::TX_SSD2:
            begin
                tx_code = `FPC_CG_SSD2;
                tx_st_d = fpc_pkg::TX_DATA;
            end
            fpc_pkg::TX_DATA:
            begin
                if (!pop_en)
                begin
                    tx_code = `FPC_CG_ESD1;
                    tx_st_d = fpc_pkg::TX_ESD2;
                end
                else if (pop_er)
                begin
                    tx_code = `FPC_CG_HALT;
                end
                else
                begin
                    tx_code = tx_enc;
                end
            end
            fpc_pkg::TX_ESD2:
            begin
                tx_code = `FPC_CG_ESD2;
                tx_st_d = fpc_pkg::TX_IDLE;
            end
            default:
            begin
                tx_code = `FPC_CG_IDLE;
                tx_st_d = fpc_pkg::TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tx_st_q <= fpc_pkg::TX_IDLE;
        end
        else if (tx_ld)
        begin
            tx_st_q <= tx_st_d;
        end
    end

    // one bit per clock, leftmost code bit first, no gaps between groups
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tx_cnt_q <= `FPC_CG_LAST;
            tx_sh_q <= `FPC_CG_IDLE;
        end
        else if (tx_ld)
        begin
            tx_cnt_q <= 3'h0;
            tx_sh_q <= tx_code;
        end
        else
        begin
            tx_cnt_q <= tx_cnt_q + 3'h1;
            tx_sh_q <= {tx_sh_q[3:0], 1'b0};
        end
    end

    assign tx_key = tx_lfsr_q[`FPC_TAP_HI] ^ tx_lfsr_q[`FPC_TAP_LO];
    assign tx_byp = scr_bypass_i || fiber_mode_i;
    assign tx_bit = tx_sh_q[4] ^ (tx_key && !tx_byp);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tx_lfsr_q <= `FPC_LFSR_SEED;
        end
        else
        begin
            tx_lfsr_q <= {tx_lfsr_q[9:0], tx_key};
        end
    end

    // nrzi: a one toggles the line; there is deliberately no bypass
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tx_line_q <= 1'b0;
        end
        else
        begin
            tx_line_q <= tx_line_q ^ tx_bit;
        end
    end
    assign tx_line_o = tx_line_q;

    // receive side
    logic rx_s1_q;
    logic rx_s2_q;
    logic rx_prev_q;
    logic rx_nrz;
    logic [10:0] rx_lfsr_q;
    logic rx_key;
    logic rx_ud;
    logic rx_lock_q;
    logic [6:0] rx_ones_q;
    logic [1:0] rx_err_q;
    logic [3:0] rx_hist_q;
    logic [4:0] rx_grp;
    logic [4:0] rx_dec;
    logic [2:0] rx_cnt_q;
    logic [2:0] rx_cnt_d;
    logic rx_last;
    fpc_pkg::fpc_rx_state_t rx_st_q;
    fpc_pkg::fpc_rx_state_t rx_st_d;
    logic rx_drop;
    logic err_inc;
    logic err_clr;
    logic out_pulse;
    logic out_dv;
    logic out_er;
    logic [3:0] out_d;
    logic rx_valid_q;
    logic rx_dv_q;
    logic rx_er_q;
    logic [3:0] rxd_q;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
            rx_prev_q <= 1'b0;
        end
        else
        begin
            rx_s1_q <= rx_line_i;
            rx_s2_q <= rx_s1_q;
            rx_prev_q <= rx_s2_q;
        end
    end

    assign rx_nrz = rx_s2_q ^ rx_prev_q;
    assign rx_key = rx_lfsr_q[`FPC_TAP_HI] ^ rx_lfsr_q[`FPC_TAP_LO];
    // unlocked, the register is loaded from inverted line bits, which equal
    // the key while idles arrive; so the same xor serves as the idle check
    assign rx_ud = fiber_mode_i ? rx_nrz : (rx_nrz ^ rx_key);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_lfsr_q <= `FPC_LFSR_SEED;
        end
        else if (rx_lock_q)
        begin
            rx_lfsr_q <= {rx_lfsr_q[9:0], rx_key};
        end
        else
        begin
            rx_lfsr_q <= {rx_lfsr_q[9:0], ~rx_nrz};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_lock_q <= 1'b0;
            rx_ones_q <= 7'h00;
        end
        else if (!rx_lock_q)
        begin
            if (!rx_ud)
            begin
                rx_ones_q <= 7'h00;
            end
            else if (rx_ones_q == `FPC_LOCK_ONES - 7'h01)
            begin
                rx_lock_q <= 1'b1;
                rx_ones_q <= 7'h00;
            end
            else
            begin
                rx_ones_q <= rx_ones_q + 7'h01;
            end
        end
        else if (rx_drop)
        begin
            rx_lock_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_err_q <= 2'h0;
        end
        else if (!rx_lock_q || err_clr)
        begin
            rx_err_q <= 2'h0;
        end
        else if (err_inc)
        begin
            rx_err_q <= rx_err_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_hist_q <= 4'hf;
        end
        else
        begin
            rx_hist_q <= {rx_hist_q[2:0], rx_ud};
        end
    end

    assign rx_grp = {rx_hist_q, rx_ud};
    assign rx_dec = fpc_dec(rx_grp);
    assign rx_last = (rx_cnt_q == 3'h1);

    always_comb
    begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_cnt_q - 3'h1;
        rx_drop = 1'b0;
        err_inc = 1'b0;
        err_clr = 1'b0;
        out_pulse = 1'b0;
        out_dv = 1'b0;
        out_er = 1'b0;
        out_d = rx_dec[3:0];
        case (rx_st_q)
            fpc_pkg::RX_WAITZ:
            begin
                // a zero is the third bit of J; two more bits complete it
                if (!rx_ud)
                begin
                    rx_st_d = fpc_pkg::RX_CHKJ;
                    rx_cnt_d = `FPC_ZERO_TAIL;
                end
            end
            fpc_pkg::RX_CHKJ:
            begin
                if (rx_last)
                begin
                    rx_cnt_d = `FPC_CG_BITS;
                    if (rx_grp == `FPC_CG_SSD1)
                    begin
                        rx_st_d = fpc_pkg::RX_CHKK;
                        err_clr = 1'b1;
                    end
                    else
                    begin
                        rx_st_d = fpc_pkg::RX_WAITZ;
                        err_inc = 1'b1;
                        rx_drop = (rx_err_q == `FPC_SSD_ERRS - 2'h1);
                    end
                end
            end
            fpc_pkg::RX_CHKK:
            begin
                if (rx_last)
                begin
                    rx_cnt_d = `FPC_CG_BITS;
                    if (rx_grp == `FPC_CG_SSD2)
                    begin
                        rx_st_d = fpc_pkg::RX_DATA;
                    end
                    else if (rx_grp == `FPC_CG_LPI)
                    begin
                        rx_st_d = fpc_pkg::RX_LPI;
                        out_pulse = 1'b1;
                        out_er = 1'b1;
                        out_d = `FPC_NIB_LPI;
                    end
                    else
                    begin
                        rx_st_d = fpc_pkg::RX_WAITZ;
                        rx_drop = 1'b1;
                    end
                end
            end
            fpc_pkg::RX_DATA:
            begin
                if (rx_last)
                begin
                    rx_cnt_d = `FPC_CG_BITS;
                    out_pulse = 1'b1;
                    if (rx_grp == `FPC_CG_ESD1)
                    begin
                        rx_st_d = fpc_pkg::RX_ESD2;
                    end
                    else
                    begin
                        out_dv = 1'b1;
                        out_er = !rx_dec[4];
                        if (rx_grp == `FPC_CG_IDLE)
                        begin
                            rx_st_d = fpc_pkg::RX_WAITZ;
                        end
                    end
                end
            end
            fpc_pkg::RX_ESD2:
            begin
                if (rx_last)
                begin
                    rx_st_d = fpc_pkg::RX_WAITZ;
                end
            end
            fpc_pkg::RX_LPI:
            begin
                if (rx_last)
                begin
                    rx_cnt_d = `FPC_CG_BITS;
                    if (rx_grp == `FPC_CG_LPI)
                    begin
                        out_pulse = 1'b1;
                        out_er = 1'b1;
                        out_d = `FPC_NIB_LPI;
                    end
                    else
                    begin
                        rx_st_d = fpc_pkg::RX_WAITZ;
                    end
                end
            end
            default:
            begin
                rx_st_d = fpc_pkg::RX_WAITZ;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_st_q <= fpc_pkg::RX_WAITZ;
            rx_cnt_q <= 3'h0;
        end
        else if (!rx_lock_q || rx_drop)
        begin
            rx_st_q <= fpc_pkg::RX_WAITZ;
            rx_cnt_q <= 3'h0;
        end
        else
        begin
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_valid_q <= 1'b0;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rxd_q <= 4'h0;
        end
        else
        begin
            rx_valid_q <= out_pulse && rx_lock_q;
            if (out_pulse && rx_lock_q)
            begin
                rx_dv_q <= out_dv;
                rx_er_q <= out_er;
                rxd_q <= out_d;
            end
        end
    end

    assign rx_valid_o = rx_valid_q;
    assign rx_dv_o = rx_dv_q;
    assign rx_er_o = rx_er_q;
    assign rxd_o = rxd_q;
    assign rx_locked_o = rx_lock_q;

    a_data_group_bits: assert property (
        (tx_ld && tx_st_q == fpc_pkg::TX_DATA && pop_en && !pop_er)
        |=> (tx_sh_q[4] == $past(tx_enc[4])) ##4 (tx_sh_q[4] == $past(tx_enc[0], 5)))
        else $error("data code-group not sent msb first");
    a_ssd_pair: assert property (
        (tx_ld && tx_code == `FPC_CG_SSD1) |-> ##5 (tx_ld && tx_code == `FPC_CG_SSD2))
        else $error("J not followed by K");
    a_esd_idle: assert property (
        (tx_ld && tx_code == `FPC_CG_ESD1)
        |-> ##5 (tx_code == `FPC_CG_ESD2) ##5 (pop_en || pop_er || tx_code == `FPC_CG_IDLE))
        else $error("T not followed by R then idle");
    a_line_nrzi: assert property (
        tx_bit |=> (tx_line_o != $past(tx_line_o)))
        else $error("one bit did not toggle the line");
    a_scr_bypass: assert property (
        tx_byp |-> (tx_bit == tx_sh_q[4]))
        else $error("bypassed stream was scrambled");
    a_lock_ones: assert property (
        $rose(rx_lock_q) |-> ($past(rx_ones_q) == `FPC_LOCK_ONES - 7'h01))
        else $error("lock without 88 idle bits");
    a_ssd_errs: assert property (
        (rx_st_q == fpc_pkg::RX_CHKJ && rx_last && rx_grp != `FPC_CG_SSD1
         && rx_err_q == 2'h2) |=> !rx_lock_q)
        else $error("third bad J kept lock");
    a_k_after_j: assert property (
        (rx_st_q == fpc_pkg::RX_CHKK && rx_last && rx_grp != `FPC_CG_SSD2
         && rx_grp != `FPC_CG_LPI) |=> !rx_lock_q)
        else $error("non-K after J kept lock");
    a_rx_invalid: assert property (
        (rx_lock_q && rx_st_q == fpc_pkg::RX_DATA && rx_last && !rx_dec[4]
         && rx_grp != `FPC_CG_ESD1) |=> (rx_valid_o && rx_dv_o && rx_er_o))
        else $error("invalid group in frame without error");
    a_rx_lpi: assert property (
        (rx_lock_q && rx_st_q == fpc_pkg::RX_LPI && rx_last && rx_grp == `FPC_CG_LPI)
        |=> (rx_er_o && !rx_dv_o && rxd_o == `FPC_NIB_LPI))
        else $error("low-power idle presented wrongly");

endmodule

`default_nettype wire

// ---- rtl/fpc_top_note_placeholder.sv ----
`default_nettype none
`default_nettype wire

// ---- tb/fpc_mac_model.sv ----
// mac model: hands transmit words {en, er, nibble} to the block over valid/ready
// assumes the bench pushes words after reset; drives on the falling edge
`default_nettype none

module fpc_mac_model (
    input wire logic clk_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [5:0] word_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0] q[$];
    logic took_q = 1'b0;

    initial tx_valid_o = 1'b0;
    initial word_o = 6'h00;

    task automatic push(input logic [5:0] w);
        q.push_back(w);
    endtask

    always @(posedge clk_i) took_q <= tx_valid_o & tx_ready_i;

    // a word stands until an edge saw ready; released data toggles so no stale value looks valid
    always @(negedge clk_i)
    begin
        if (!tx_valid_o || took_q)
        begin
            if (q.size() != 0)
            begin
                word_o <= q.pop_front();
                tx_valid_o <= 1'b1;
            end
            else
            begin
                word_o <= ~word_o;
                tx_valid_o <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// bench: transmit line looped back to receive, frames checked nibble by nibble
// assumes fpc_top and fpc_mac_model; one clock at 20 MHz
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic scr_bypass = 1'b0;
    logic lpi_on = 1'b0;
    logic flip = 1'b0;
    int lpis = 0;
    logic fiber_mode = 1'b0;
    logic tx_valid, tx_ready, tx_line, rx_valid, rx_dv, rx_er, rx_locked, prev;
    logic [5:0] word;
    logic [3:0] rxd;
    logic [4:0] exp_q[$];
    logic [31:0] seed = 32'h6755f08c;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int ends = 0;

    always #25 clk_i = ~clk_i;

    fpc_mac_model i_mac (.clk_i(clk_i), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
        .word_o(word));

    fpc_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .tx_en_i(word[5]), .tx_er_i(word[4]), .txd_i(word[3:0]),
        .scr_bypass_i(scr_bypass), .fiber_mode_i(fiber_mode), .tx_line_o(tx_line),
        .rx_line_i(tx_line ^ flip), .rx_valid_o(rx_valid), .rx_dv_o(rx_dv), .rx_er_o(rx_er),
        .rxd_o(rxd), .rx_locked_o(rx_locked));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // a halted word comes back as an error with a zero nibble
    function automatic logic [4:0] expect_rx(input logic er, input logic [3:0] nib);
        return er ? 5'h10 : {1'b0, nib};
    endfunction

    task automatic conclude();
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic restart(input logic fib, input logic byp);
        arst_n_i = 1'b0;
        fiber_mode = fib;
        scr_bypass = byp;
        ends = 0;
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
    endtask

    // two preamble words become J K; a length of 16 walks every nibble value
    task automatic frame(input int n, input logic bad);
        logic [31:0] r;
        logic [3:0] nib;
        logic e;
        i_mac.push(6'h25);
        i_mac.push(6'h25);
        for (int i = 0; i < n; i++)
        begin
            r = rnd();
            nib = (n == 16) ? i[3:0] : r[3:0];
            e = bad && (i == n / 2);
            i_mac.push({1'b1, e, nib});
            exp_q.push_back(expect_rx(e, nib));
        end
        i_mac.push({2'b00, r[7:4]});
    endtask

    always @(negedge clk_i)
    begin
        cycles++;
        if (arst_n_i && !scr_bypass && rx_valid === 1'b1)
        begin
            if (rx_dv === 1'b1)
                chk({3'h0, rx_er, rxd}, {3'h0, exp_q.size() ? exp_q.pop_front() : 5'h1f});
            else if (lpi_on)
            begin
                chk({3'h0, rx_er, rxd}, 8'h11);
                lpis++;
            end
            else
            begin
                chk({7'h0, rx_er}, 8'h00);
                ends++;
            end
        end
        if (cycles > 20000)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        for (int m = 0; m < 2; m++)
        begin
            restart(m[0], 1'b0);
            repeat (80) @(negedge clk_i);
            chk({7'h0, rx_locked}, 8'h00);
            for (int i = 0; i < 300 && rx_locked !== 1'b1; i++) @(negedge clk_i);
            chk({7'h0, rx_locked}, 8'h01);
            for (int f = 0; f < 5; f++)
            begin
                // frames 1 and 2 go back to back with no idle wait between them
                frame(f == 0 ? 16 : 1 + (rnd() % 8), f == 3);
                if (f != 1)
                begin
                    for (int i = 0; i < 600 && ends != f + 1; i++) @(negedge clk_i);
                    chk(ends[7:0], f[7:0] + 8'h01);
                    chk(8'(exp_q.size()), 8'h00);
                end
            end
            // four low-power idle words in a row, then idles again
            lpi_on = 1'b1;
            lpis = 0;
            repeat (4) i_mac.push(6'h11);
            repeat (150) @(negedge clk_i);
            lpi_on = 1'b0;
            chk(8'(lpis), 8'h03);
            // lone line faults in idle read as broken J groups; the third drops lock
            for (int k = 0; k < 3; k++)
            begin
                flip = 1'b1;
                @(negedge clk_i);
                flip = 1'b0;
                repeat (20) @(negedge clk_i);
            end
            chk({7'h0, rx_locked}, 8'h00);
            for (int i = 0; i < 300 && rx_locked !== 1'b1; i++) @(negedge clk_i);
            chk({7'h0, rx_locked}, 8'h01);
        end
        // unscrambled idle ones must toggle the line every bit
        restart(1'b0, 1'b1);
        repeat (6) @(negedge clk_i);
        for (int i = 0; i < 40; i++)
        begin
            prev = tx_line;
            @(negedge clk_i);
            chk({7'h0, tx_line}, {7'h0, ~prev});
        end
        conclude();
    end
endmodule

`default_nettype wire
